/* hdl/dutc_timer_map.vh */
// Register map, field positions and constants of the dual up timer
`ifndef DUTC_TIMER_MAP_VH
`define DUTC_TIMER_MAP_VH

// Register indexes; byte address is four times the index
`define DUTC_IDX_CTRL   8'h88
`define DUTC_IDX_MODE   8'h89
`define DUTC_IDX_T0LOW  8'h8A
`define DUTC_IDX_T1LOW  8'h8B
`define DUTC_IDX_T0HIGH 8'h8C
`define DUTC_IDX_T1HIGH 8'h8D
`define DUTC_IDX_IRQEN  8'h8E
`define DUTC_IDX_RATE   8'hE7

// timer_control fields
`define DUTC_CTRL_F1 7
`define DUTC_CTRL_R1 6
`define DUTC_CTRL_F0 5
`define DUTC_CTRL_R0 4

// timer_mode_select fields
`define DUTC_MODE_G1  7
`define DUTC_MODE_S1  6
`define DUTC_MODE_M1H 5
`define DUTC_MODE_M1L 4
`define DUTC_MODE_G0  3
`define DUTC_MODE_S0  2
`define DUTC_MODE_M0H 1
`define DUTC_MODE_M0L 0

// timer_rate_select fields
`define DUTC_RATE_D0H 6
`define DUTC_RATE_D0L 4
`define DUTC_RATE_D1H 2
`define DUTC_RATE_D1L 0

// timer_irq_enable fields
`define DUTC_IRQEN_E0 0
`define DUTC_IRQEN_E1 1

// Mode codes
`define DUTC_MODE_13BIT  2'h0
`define DUTC_MODE_16BIT  2'h1
`define DUTC_MODE_RELOAD 2'h2
`define DUTC_MODE_SPLIT  2'h3

// Reset values and timing
`define DUTC_RST_BYTE   8'h00
`define DUTC_CPU_DIV12  4'hC

`endif

/* hdl/dutc_timer.v */
// Dual up timer/counter with Avalon-MM register slave
// Notes on behaviour
// - Two timers; timer 0 four modes, timer 1 three
// - Per-timer clock select: cpu or oscillator
// - Gate bit lets pin level pause the clock
// - Mode 0: 13-bit, flag on 0xFF1F wrap
// - Irq enable hands flag to interrupt controller
// - Mode 1: 16-bit, flag on 0xFFFF wrap
// - Mode 2: low byte reloads from high byte
// - Mode 3: two bytes, high at cpu/12
// - Mode 3 gating only affects low byte
// - Mode 3 high byte uses timer 1 run/flag
// - Timer 0 mode 3: timer 1 counts flagless
// - Flag set on overflow, cleared by service, or by firmware with irq disabled
// - Control register: flags and run bits layout
// - Mode register: gate, select, mode per timer
// - Rate register: two three-bit dividers
// - Mode codes 00..11; 11 reserved timer 1
// - Select 0 cpu/12, select 1 osc/rate
// - Divider codes 000..111 give 128..1
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dutc_timer_map.vh"

module dutc_timer #(
  parameter CPU_CLK_DIV = 1,                 // ref_clk cycles per cpu clock
  parameter OSC_CLK_DIV = 1                  // ref_clk cycles per osc clock
) (
  input  wire        ref_clk,                // System clock
  input  wire        arst_n,                 // Async reset, active low
  input  wire [9:0]  address,                // Avalon byte address
  input  wire        read,                   // Avalon read
  input  wire        write,                  // Avalon write
  input  wire [31:0] writedata,              // Avalon write data
  input  wire [3:0]  byteenable,             // Avalon byte enables
  output reg  [31:0] readdata,               // Avalon read data
  output wire        waitrequest,            // Avalon wait request
  input  wire        ext_irq_pin_zero,       // Gate pin of timer 0
  input  wire        ext_irq_pin_one,        // Gate pin of timer 1
  input  wire        timer0_irq_service,     // Controller serviced timer 0
  input  wire        timer1_irq_service,     // Controller serviced timer 1
  output reg         timer0_overflow_flag,   // Timer 0 overflow flag
  output reg         timer1_overflow_flag,   // Timer 1 overflow flag
  output wire        timer0_irq_request,     // Flag gated by enable
  output wire        timer1_irq_request      // Flag gated by enable
);

  // Registers
  reg  [7:0] timer_mode_select;
  reg  [7:0] timer_rate_select;
  reg  [1:0] timer_irq_enable;
  reg        timer0_run;
  reg        timer1_run;
  reg  [7:0] timer0_count_high;
  reg  [7:0] timer0_count_low;
  reg  [7:0] timer1_count_high;
  reg  [7:0] timer1_count_low;
  reg        ack;

  // Bus slave: one wait cycle, then answer
  wire       req     = read | write;
  wire [7:0] idx     = address[9:2];
  wire       wr_go   = write & ack & byteenable[0];
  wire [7:0] wd      = writedata[7:0];

  // Register write strobes
  wire       wr_ctrl  = wr_go & (idx == `DUTC_IDX_CTRL);
  wire       wr_mode  = wr_go & (idx == `DUTC_IDX_MODE);
  wire       wr_rate  = wr_go & (idx == `DUTC_IDX_RATE);
  wire       wr_irqen = wr_go & (idx == `DUTC_IDX_IRQEN);
  wire       wr_t0l   = wr_go & (idx == `DUTC_IDX_T0LOW);
  wire       wr_t0h   = wr_go & (idx == `DUTC_IDX_T0HIGH);
  wire       wr_t1l   = wr_go & (idx == `DUTC_IDX_T1LOW);
  wire       wr_t1h   = wr_go & (idx == `DUTC_IDX_T1HIGH);

  assign waitrequest = req & ~ack;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // Mode fields
  wire [1:0] timer0_mode_field = timer_mode_select[`DUTC_MODE_M0H:`DUTC_MODE_M0L];
  wire [1:0] timer1_mode_field = timer_mode_select[`DUTC_MODE_M1H:`DUTC_MODE_M1L];
  wire       split_mode        = (timer0_mode_field == `DUTC_MODE_SPLIT);

  wire [7:0] ctrl_view = {timer1_overflow_flag, timer1_run,
                          timer0_overflow_flag, timer0_run, 4'h0};
  wire [7:0] rate_view = {1'b0, timer_rate_select[6:4],
                          1'b0, timer_rate_select[2:0]};

  // Read data latched while waitrequest is high
  reg [7:0] rd_byte;
  always @* begin
    case (idx)
      `DUTC_IDX_CTRL:   rd_byte = ctrl_view;
      `DUTC_IDX_MODE:   rd_byte = timer_mode_select;
      `DUTC_IDX_RATE:   rd_byte = rate_view;
      `DUTC_IDX_T0LOW:  rd_byte = timer0_count_low;
      `DUTC_IDX_T0HIGH: rd_byte = timer0_count_high;
      `DUTC_IDX_T1LOW:  rd_byte = timer1_count_low;
      `DUTC_IDX_T1HIGH: rd_byte = timer1_count_high;
      `DUTC_IDX_IRQEN:  rd_byte = {6'h00, timer_irq_enable};
      default:          rd_byte = 8'h00;
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      readdata <= 32'h00000000;
    end else if (read & ~ack) begin
      readdata <= {24'h000000, rd_byte};
    end
  end

  // Configuration registers
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_mode_select <= `DUTC_RST_BYTE;
      timer_rate_select <= `DUTC_RST_BYTE;
      timer_irq_enable  <= 2'h0;
      timer0_run        <= 1'b0;
      timer1_run        <= 1'b0;
    end else begin
      if (wr_mode) begin
        timer_mode_select <= wd;
      end
      if (wr_rate) begin
        timer_rate_select <= {1'b0, wd[`DUTC_RATE_D0H:`DUTC_RATE_D0L],
                              1'b0, wd[`DUTC_RATE_D1H:`DUTC_RATE_D1L]};
      end
      if (wr_irqen) begin
        timer_irq_enable <= wd[1:0];
      end
      if (wr_ctrl) begin
        timer0_run <= wd[`DUTC_CTRL_R0];
        timer1_run <= wd[`DUTC_CTRL_R1];
      end
    end
  end

  // Base rate enables from ref_clk
  reg  [7:0] cpu_div_cnt;
  reg  [7:0] osc_div_cnt;
  wire       cpu_tick = (cpu_div_cnt == CPU_CLK_DIV[7:0] - 8'h01);
  wire       osc_tick = (osc_div_cnt == OSC_CLK_DIV[7:0] - 8'h01);

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_div_cnt <= 8'h00;
      osc_div_cnt <= 8'h00;
    end else begin
      cpu_div_cnt <= cpu_tick ? 8'h00 : cpu_div_cnt + 8'h01;
      osc_div_cnt <= osc_tick ? 8'h00 : osc_div_cnt + 8'h01;
    end
  end

  // Divide cpu clock by twelve
  reg  [3:0] cpu12_cnt;
  wire       cpu12_tick = cpu_tick & (cpu12_cnt == `DUTC_CPU_DIV12 - 4'h1);

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu12_cnt <= 4'h0;
    end else if (cpu_tick) begin
      cpu12_cnt <= (cpu12_tick) ? 4'h0 : cpu12_cnt + 4'h1;
    end
  end

  // Shared free-running oscillator prescaler
  reg [6:0] osc_presc;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_presc <= 7'h00;
    end else if (osc_tick) begin
      osc_presc <= osc_presc + 7'h01;
    end
  end

  // Per-timer pin filter and clock source
  wire [1:0] pin_raw  = {ext_irq_pin_one, ext_irq_pin_zero};
  wire [1:0] gate_bit = {timer_mode_select[`DUTC_MODE_G1],
                         timer_mode_select[`DUTC_MODE_G0]};
  wire [1:0] sel_bit  = {timer_mode_select[`DUTC_MODE_S1],
                         timer_mode_select[`DUTC_MODE_S0]};
  wire [5:0] div_code = {timer_rate_select[6:4], timer_rate_select[2:0]};
  wire [1:0] src_tick;
  wire [1:0] gate_open;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_timer
      reg        s1;
      reg        s2;
      reg        s3;
      reg        pin_level;
      wire [2:0] code = (gi == 0) ? div_code[5:3] : div_code[2:0];
      wire [6:0] mask = 7'h7F >> code;
      wire       rate_tick = osc_tick & ((osc_presc & mask) == mask);

      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          s1        <= 1'b0;
          s2        <= 1'b0;
          s3        <= 1'b0;
          pin_level <= 1'b0;
        end else begin
          s1 <= pin_raw[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            pin_level <= s3;
          end
        end
      end

      assign src_tick[gi]  = sel_bit[gi] ? rate_tick : cpu12_tick;
      assign gate_open[gi] = ~gate_bit[gi] | pin_level;
    end
  endgenerate

  // One count step for modes 0..2: {overflow, high, low}
  function [16:0] step;
    input [1:0] m;
    input [7:0] h;
    input [7:0] l;
    reg   [16:0] sum;
    begin
      sum = {1'b0, h, l} + 17'h00001;
      case (m)
        `DUTC_MODE_13BIT: begin
          // Upper three low bits hold, five bits count
          if (l[4:0] == 5'h1F) begin
            step = {(h == 8'hFF), h + 8'h01, l[7:5], 5'h00};
          end else begin
            step = {1'b0, h, l[7:5], l[4:0] + 5'h01};
          end
        end
        `DUTC_MODE_16BIT: begin
          step = sum;
        end
        `DUTC_MODE_RELOAD: begin
          if (l == 8'hFF) begin
            step = {1'b1, h, h};
          end else begin
            step = {1'b0, h, l + 8'h01};
          end
        end
        default: begin
          step = {1'b0, h, l};
        end
      endcase
    end
  endfunction

  // Count enables
  wire tick0  = src_tick[0] & gate_open[0] & timer0_run;
  wire tick0h = cpu12_tick & timer1_run;
  wire tick1  = src_tick[1] & gate_open[1] & (split_mode | timer1_run);

  reg  [7:0] next_t0h;
  reg  [7:0] next_t0l;
  reg  [7:0] next_t1h;
  reg  [7:0] next_t1l;
  reg        next_f0;
  reg        next_f1;
  reg        ovf0;
  reg        ovf1;
  reg [16:0] st0;
  reg [16:0] st1;

  always @* begin
    next_t0h = timer0_count_high;
    next_t0l = timer0_count_low;
    next_t1h = timer1_count_high;
    next_t1l = timer1_count_low;
    ovf0     = 1'b0;
    ovf1     = 1'b0;
    st0      = step(timer0_mode_field, timer0_count_high, timer0_count_low);
    st1      = step(timer1_mode_field, timer1_count_high, timer1_count_low);
    // Timer 0
    if (split_mode) begin
      if (tick0) begin
        next_t0l = timer0_count_low + 8'h01;
        ovf0     = (timer0_count_low == 8'hFF);
      end
      if (tick0h) begin
        next_t0h = timer0_count_high + 8'h01;
        ovf1     = (timer0_count_high == 8'hFF);
      end
    end else if (tick0) begin
      next_t0h = st0[15:8];
      next_t0l = st0[7:0];
      ovf0     = st0[16];
    end
    // Timer 1; mode 3 code holds it
    if (tick1) begin
      next_t1h = st1[15:8];
      next_t1l = st1[7:0];
      if (!split_mode) begin
        ovf1 = st1[16];
      end
    end
    // Firmware writes win over counting
    if (wr_t0h) begin
      next_t0h = wd;
    end
    if (wr_t0l) begin
      next_t0l = wd;
    end
    if (wr_t1h) begin
      next_t1h = wd;
    end
    if (wr_t1l) begin
      next_t1l = wd;
    end
  end

  // Flags: firmware only when irq disabled; set wins
  always @* begin
    next_f0 = timer0_overflow_flag;
    next_f1 = timer1_overflow_flag;
    if (wr_ctrl && !timer_irq_enable[`DUTC_IRQEN_E0]) begin
      next_f0 = wd[`DUTC_CTRL_F0];
    end
    if (wr_ctrl && !timer_irq_enable[`DUTC_IRQEN_E1]) begin
      next_f1 = wd[`DUTC_CTRL_F1];
    end
    if (timer0_irq_service) begin
      next_f0 = 1'b0;
    end
    if (timer1_irq_service) begin
      next_f1 = 1'b0;
    end
    if (ovf0) begin
      next_f0 = 1'b1;
    end
    if (ovf1) begin
      next_f1 = 1'b1;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer0_count_high    <= `DUTC_RST_BYTE;
      timer0_count_low     <= `DUTC_RST_BYTE;
      timer1_count_high    <= `DUTC_RST_BYTE;
      timer1_count_low     <= `DUTC_RST_BYTE;
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
    end else begin
      timer0_count_high    <= next_t0h;
      timer0_count_low     <= next_t0l;
      timer1_count_high    <= next_t1h;
      timer1_count_low     <= next_t1l;
      timer0_overflow_flag <= next_f0;
      timer1_overflow_flag <= next_f1;
    end
  end

  assign timer0_irq_request = timer0_overflow_flag & timer_irq_enable[`DUTC_IRQEN_E0];
  assign timer1_irq_request = timer1_overflow_flag & timer_irq_enable[`DUTC_IRQEN_E1];

endmodule // dutc_timer

`default_nettype wire

/* sim/dutc_timer_properties.sv */
// Port checker of the dual up timer
`timescale 1ns/100ps
`default_nettype none
module dutc_timer_properties (
  input wire logic        ref_clk,              // Clock
  input wire logic        arst_n,               // Reset
  input wire logic        read,                 // Read
  input wire logic        write,                // Write
  input wire logic [31:0] readdata,             // Read data
  input wire logic        waitrequest,          // Wait
  input wire logic        timer0_irq_service,   // Service 0
  input wire logic        timer1_irq_service,   // Service 1
  input wire logic        timer0_overflow_flag, // Flag 0
  input wire logic        timer1_overflow_flag, // Flag 1
  input wire logic        timer0_irq_request,   // Irq 0
  input wire logic        timer1_irq_request    // Irq 1
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_wait_first; $rose(read | write) |-> waitrequest; endproperty
  a_wait_first: assert property (p_wait_first) else $error("new request not held off");
  property p_wait_one; (read | write) && waitrequest |=> !waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
  property p_wait_idle; !(read | write) |-> !waitrequest; endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait without request");
  property p_rd_upper; read && !waitrequest |-> readdata[31:8] == 24'h000000; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read data not zero");
  property p_rd_stable; !(read && waitrequest) |=> $stable(readdata); endproperty
  a_rd_stable: assert property (p_rd_stable) else $error("read data moved");
  property p_fell0; $fell(timer0_overflow_flag) |-> $past(timer0_irq_service) || $past(write); endproperty
  a_fell0: assert property (p_fell0) else $error("flag 0 cleared without cause");
  property p_fell1; $fell(timer1_overflow_flag) |-> $past(timer1_irq_service) || $past(write); endproperty
  a_fell1: assert property (p_fell1) else $error("flag 1 cleared without cause");
  property p_irq0; timer0_irq_request |-> timer0_overflow_flag; endproperty
  a_irq0: assert property (p_irq0) else $error("irq 0 without flag");
  property p_irq1; timer1_irq_request |-> timer1_overflow_flag; endproperty
  a_irq1: assert property (p_irq1) else $error("irq 1 without flag");
  c_read: cover property (read && !waitrequest);
  c_flag0: cover property ($rose(timer0_overflow_flag));
  c_irq1: cover property ($rose(timer1_irq_request));
  c_clear: cover property ($fell(timer1_overflow_flag));
endmodule // dutc_timer_properties
bind dutc_timer dutc_timer_properties u_props (.ref_clk(ref_clk), .arst_n(arst_n), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .timer0_irq_service(timer0_irq_service),
  .timer1_irq_service(timer1_irq_service), .timer0_overflow_flag(timer0_overflow_flag),
  .timer1_overflow_flag(timer1_overflow_flag), .timer0_irq_request(timer0_irq_request),
  .timer1_irq_request(timer1_irq_request));
`default_nettype wire

/* sim/dutc_timer_bench.sv */
// Self-checking bench of the dual up timer
`timescale 1ns/100ps
`default_nettype none
`include "dutc_timer_map.vh"
module dutc_timer_bench;
  logic        ref_clk, arst_n, read, write, pin0, pin1, svc0, svc1;
  logic        waitrequest, flag0, flag1, irq0, irq1;
  logic [9:0]  address;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  logic [15:0] q[$];
  logic [7:0]  r;
  logic [7:0]  idxs [9] = '{`DUTC_IDX_CTRL, `DUTC_IDX_MODE, `DUTC_IDX_T0LOW, `DUTC_IDX_T1LOW,
                            `DUTC_IDX_T0HIGH, `DUTC_IDX_T1HIGH, `DUTC_IDX_IRQEN, `DUTC_IDX_RATE, 8'h00};
  int          errors = 0;
  int          compares = 0;
  dutc_timer uut (.ref_clk(ref_clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .ext_irq_pin_zero(pin0), .ext_irq_pin_one(pin1), .timer0_irq_service(svc0),
    .timer1_irq_service(svc1), .timer0_overflow_flag(flag0), .timer1_overflow_flag(flag1),
    .timer0_irq_request(irq0), .timer1_irq_request(irq1));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge ref_clk);
    address <= {idx, 2'b00};
    writedata <= {24'h000000, d};
    byteenable <= be;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) errors++;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    acc(1'b1, idx, d, 4'h1);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
    q.push_back({m, e});
    acc(1'b0, idx, 8'h00, 4'hF);
  endtask
  // Oldest noted read result against the data at the answering edge
  always @(posedge ref_clk) begin
    if (read === 1'b1 && waitrequest === 1'b0 && q.size() > 0) begin
      check(readdata[7:0] & q[0][15:8], q[0][7:0], "readdata");
      void'(q.pop_front());
    end
  end
  task automatic wait_flag(input int f, input int lim);
    int n;
    n = 0;
    while ((f ? flag1 : flag0) !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    check({7'h00, f ? flag1 : flag0}, 8'h01, "flag");
  endtask
  task automatic arm(input logic [7:0] md, input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] ct);
    wr(`DUTC_IDX_CTRL, 8'h00);
    wr(`DUTC_IDX_MODE, md);
    wr(`DUTC_IDX_T0HIGH, hi);
    wr(`DUTC_IDX_T0LOW, lo);
    wr(`DUTC_IDX_CTRL, ct);
  endtask
  // Free-running prescaler phase leaves one tick of slack
  task automatic rate_run(input logic [7:0] md, input logic [7:0] rt, input int n, input logic [7:0] e);
    wr(`DUTC_IDX_RATE, rt);
    arm(md, 8'h00, 8'h00, 8'h10);
    repeat (n) @(posedge ref_clk);
    wr(`DUTC_IDX_CTRL, 8'h00);
    rd(`DUTC_IDX_T0LOW, 8'hFC, e);
  endtask
  task automatic pulse(input int f);
    @(posedge ref_clk);
    if (f) svc1 <= 1'b1;
    else svc0 <= 1'b1;
    @(posedge ref_clk);
    svc0 <= 1'b0;
    svc1 <= 1'b0;
    @(posedge ref_clk);
  endtask
  initial begin
    #160000;
    errors++;
    wrap_up;
  end
  initial begin
    arst_n = 1'b0;
    {read, write, svc0, svc1} = 4'h0;
    {pin0, pin1} = 2'b11;
    address = 10'h000;
    writedata = 32'h00000000;
    byteenable = 4'h0;
    r = 8'($urandom(61));
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 9; i++) rd(idxs[i], 8'hFF, 8'h00);
    $display("test reset done");
    r = 8'($urandom);
    wr(`DUTC_IDX_MODE, r);
    rd(`DUTC_IDX_MODE, 8'hFF, r);
    wr(`DUTC_IDX_RATE, r);
    rd(`DUTC_IDX_RATE, 8'hFF, r & 8'h77);
    acc(1'b1, `DUTC_IDX_T1HIGH, r | 8'h01, 4'h0);
    rd(`DUTC_IDX_T1HIGH, 8'hFF, 8'h00);
    wr(`DUTC_IDX_CTRL, 8'hAF);
    rd(`DUTC_IDX_CTRL, 8'hFF, 8'hA0);
    wr(`DUTC_IDX_T0LOW, r);
    repeat (40) @(posedge ref_clk);
    rd(`DUTC_IDX_T0LOW, 8'hFF, r);
    $display("test registers done");
    wr(`DUTC_IDX_RATE, 8'h70);
    arm(8'h05, 8'hFF, 8'hF0, 8'h10);
    wait_flag(0, 60);
    wr(`DUTC_IDX_CTRL, 8'h20);
    rd(`DUTC_IDX_T0HIGH, 8'hFF, 8'h00);
    rd(`DUTC_IDX_T0LOW, 8'hF0, 8'h00);
    arm(8'h04, 8'hFF, 8'h10, 8'h10);
    wait_flag(0, 60);
    wr(`DUTC_IDX_CTRL, 8'h20);
    rd(`DUTC_IDX_T0HIGH, 8'hFF, 8'h00);
    rd(`DUTC_IDX_T0LOW, 8'hE0, 8'h00);
    arm(8'h06, 8'hF0, 8'hFE, 8'h10);
    wait_flag(0, 20);
    wr(`DUTC_IDX_CTRL, 8'h20);
    rd(`DUTC_IDX_T0LOW, 8'hF0, 8'hF0);
    rd(`DUTC_IDX_T0HIGH, 8'hFF, 8'hF0);
    $display("test modes done");
    wr(`DUTC_IDX_RATE, 8'h77);
    wr(`DUTC_IDX_T1LOW, 8'h00);
    arm(8'h57, 8'h00, 8'h00, 8'h00);
    wr(`DUTC_IDX_T1HIGH, 8'hFF);
    wr(`DUTC_IDX_T1LOW, 8'hFF);
    repeat (100) @(posedge ref_clk);
    rd(`DUTC_IDX_T1HIGH, 8'hFF, 8'h00);
    check({7'h00, flag1}, 8'h00, "flag1");
    pin0 <= 1'b0;
    arm(8'h5F, 8'hFF, 8'hFF, 8'h50);
    wait_flag(1, 40);
    check({7'h00, flag0}, 8'h00, "flag0");
    pin0 <= 1'b1;
    wait_flag(0, 20);
    $display("test split done");
    wr(`DUTC_IDX_MODE, 8'h00);
    wr(`DUTC_IDX_CTRL, 8'hA0);
    wr(`DUTC_IDX_IRQEN, 8'h03);
    @(posedge ref_clk);
    check({6'h00, irq1, irq0}, 8'h03, "irq");
    wr(`DUTC_IDX_CTRL, 8'h00);
    @(posedge ref_clk);
    check({6'h00, flag1, flag0}, 8'h03, "flags");
    pulse(0);
    check({6'h00, flag1, flag0}, 8'h02, "flags");
    pulse(1);
    check({6'h00, flag1, flag0}, 8'h00, "flags");
    wr(`DUTC_IDX_IRQEN, 8'h00);
    $display("test irq done");
    pin1 <= 1'b0;
    wr(`DUTC_IDX_MODE, 8'hE0);
    wr(`DUTC_IDX_T1HIGH, 8'hF0);
    wr(`DUTC_IDX_T1LOW, 8'hFE);
    wr(`DUTC_IDX_CTRL, 8'h40);
    repeat (20) @(posedge ref_clk);
    rd(`DUTC_IDX_T1LOW, 8'hFF, 8'hFE);
    check({7'h00, flag1}, 8'h00, "flag1");
    pin1 <= 1'b1;
    wait_flag(1, 20);
    wr(`DUTC_IDX_CTRL, 8'h00);
    rd(`DUTC_IDX_T1LOW, 8'hF0, 8'hF0);
    $display("test timer1 done");
    rate_run(8'h01, 8'h00, 118, 8'h08);
    rate_run(8'h05, 8'h40, 238, 8'h1C);
    rate_run(8'h05, 8'h00, 254, 8'h00);
    $display("test rates done");
    wrap_up;
  end
endmodule // dutc_timer_bench
`default_nettype wire
